// file: bench/lsu_model.sv
// Behavioural 128-bit load/store unit with adjustable latency
module lsu_model
	import state_rf_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// Request, latency and answer
	input  wire mem_req_s   req_i,
	input  wire logic [2:0] lat_i,
	output mem_rsp_s        rsp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	mem_req_s   hold;
	int         cnt;

	always @(posedge mclk_i) begin
		rsp_o.valid <= 1'b0;
		rsp_o.rdata <= ~rsp_o.rdata; // Stale data is inverted every cycle it is not reloaded
		if (sys_rst_i) begin
			cnt   <= 0;
			rsp_o <= '0;
			for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
		end else if (req_i.valid) begin
			hold <= req_i;
			cnt  <= lat_i + 1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				rsp_o.valid <= 1'b1;
				for (int i = 0; i < 16; i++) begin
					if (hold.write) begin
						mem[hold.addr[7:0] + i] <= hold.wdata[127-8*i -: 8];
					end else begin
						rsp_o.rdata[127-8*i -: 8] <= mem[hold.addr[7:0] + i];
					end
				end
			end
		end
	end
endmodule : lsu_model

// file: bench/tb_top.sv
// Self-checking bench: random state register traffic against a memory model
module tb_top
	import state_rf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         mclk_i    = 1'b0;
	logic         sys_rst_i = 1'b1;
	state_cmd_s   cmd       = '0;
	mem_req_s     req;
	mem_rsp_s     rsp;
	logic         busy, aerr, done;
	logic [255:0] st;
	logic [2:0]   lat       = 3'h0;
	logic [127:0] ex [2];
	logic [127:0] shadow [16];
	logic [127:0] wd;
	logic [31:0]  a;
	logic         d, s;
	int           num_errors = 0;
	int           checked    = 0;
	int           seed       = 32'h6A43F7DC;
	int           n, r;
	state_op_e    ops [5] = '{OP_WRITE, OP_MOVE, OP_SHIFT, OP_STORE, OP_LOAD};

	always #12.5 mclk_i = ~mclk_i;

	aes_state_regfile_shiftrow u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.cmd_i(cmd), .busy_o(busy), .mem_req_o(req), .mem_rsp_i(rsp),
		.align_err_o(aerr), .done_o(done), .state_o(st));
	lsu_model u_mem (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req),
		.lat_i(lat), .rsp_o(rsp));

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [127:0] rot(input logic [127:0] v);
		int src [16] = '{0, 5, 10, 15, 4, 9, 14, 3, 8, 13, 2, 7, 12, 1, 6, 11};
		for (int k = 0; k < 16; k++) rot[127-8*k -: 8] = v[127-8*src[k] -: 8];
	endfunction : rot

	task automatic issue(input state_op_e op, input logic dd, ss,
		input logic [31:0] aa, input logic [127:0] w, output int cyc);
		logic [31:0] b;
		b = $random(seed);
		@(negedge mclk_i);
		cmd = '{1'b1, op, dd, ss, b, aa - b, w};
		@(negedge mclk_i);
		cmd.valid = 1'b0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 40) begin
			@(negedge mclk_i);
			cyc++;
		end
		if (cyc == 40) chk(128'h0, 128'h1);
	endtask : issue

	task automatic test_done();
		if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		test_done();
	end

	initial begin
		repeat (5) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		chk(st[127:0], '0);
		chk(st[255:128], '0);
		wd = 128'h00112233_44556677_8899AABB_CCDDEEFF;
		issue(OP_WRITE, 1'b0, 1'b0, 32'h0, wd, n);
		issue(OP_SHIFT, 1'b0, 1'b0, 32'h0, '0, n);
		chk(st[127:0], 128'h0055AAFF_4499EE33_88DD2277_CC1166BB);
		ex[0] = rot(wd);
		ex[1] = '0;
		for (int i = 0; i < 16; i++) shadow[i] = '0;
		for (int i = 1; i < 16; i += 7) begin
			issue(ops[3 + i[0]], 1'b1, 1'b0, 32'h40 + i, '0, n);
			chk(128'(aerr), 128'h1);
			chk(128'(n), 128'h1);
		end
		// Command during a pending load must be ignored
		lat = 3'h7;
		fork
			issue(OP_LOAD, 1'b1, 1'b0, 32'h80, '0, n);
			begin
				repeat (3) @(negedge mclk_i);
				chk(128'(busy), 128'h1);
				cmd = '{1'b1, OP_WRITE, 1'b0, 1'b0, '0, '0, '1};
				@(negedge mclk_i);
				cmd.valid = 1'b0;
			end
		join
		chk(128'(busy), 128'h0);
		chk(128'(n), 128'hB);
		chk(st[127:0], ex[0]);
		chk(st[255:128], ex[1]);
		for (int i = 0; i < 80; i++) begin
			r   = {$random(seed)} % 5;
			d   = 1'($random(seed));
			s   = 1'($random(seed));
			a   = $random(seed) & 32'hF0;
			lat = 3'($random(seed));
			wd  = {$random(seed), $random(seed), $random(seed), $random(seed)};
			issue(ops[r], d, s, a, wd, n);
			case (r)
				0: ex[d] = wd;
				1: ex[d] = ex[s];
				2: begin
					ex[d] = rot(ex[d]);
					chk(128'(n), 128'h1);
				end
				3: begin
					shadow[a[7:4]] = ex[s];
					chk(req.wdata, ex[s]);
					chk(128'(req.write), 128'h1);
					chk(128'(u_mem.mem[a[7:0]]), 128'(ex[s][127:120]));
				end
				default: ex[d] = shadow[a[7:4]];
			endcase
			if (r > 2) chk(128'(req.addr), 128'(a));
			chk(st[127:0], ex[0]);
			chk(st[255:128], ex[1]);
			chk(128'(aerr), 128'h0);
		end
		test_done();
	end
endmodule : tb_top

// file: hw/aes_state_regfile_shiftrow.sv
// Top: state register file with move, load, store and row rotation
// Operation
// RL1: Two separate 128-bit state registers
// RL2: Move copies one register to another
// RL3: Address is general register base plus immediate
// RL4: Whole 128 bits in one memory access
// RL5: Accesses must be 16-byte aligned
// RL6: State registers are cipher source and destination
// RL7: Byte 0 at bits 127:120, descending
// RL8: Row one unchanged
// RL9: Rows two to four rotate left 1,2,3
// RL10: Row two takes bytes 5,9,13,1
// RL11: Row three takes bytes 10,14,2,6
// RL12: Row four bytes 3,7,11 take 15,3,7
// RL13: Rotation completes in a single cycle
// RL14: Result concatenated, written back to same register
// RL15: Lowest memory byte lands in bits 127:120
// RL16: Output byte 15 takes input byte 11
module aes_state_regfile_shiftrow
	import state_rf_pkg::*;
(
	// Clock and reset
	input  wire logic                   mclk_i,
	input  wire logic                   sys_rst_i,
	// Command from host pipeline
	input  wire state_cmd_s             cmd_i,
	output logic                        busy_o,
	// Load/store unit
	output mem_req_s                    mem_req_o,
	input  wire mem_rsp_s               mem_rsp_i,
	// Status and read-back
	output logic                        align_err_o,
	output logic                        done_o,
	output logic [NUM_REGS*STATE_W-1:0] state_o
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01
	} ctl_state_e;

	typedef struct packed {
		ctl_state_e         st;
		mem_req_s           req;
		logic [SEL_W-1:0]   ld_dst;
		logic               busy;
		logic               align_err;
		logic               done;
	} ctl_s;

	ctl_s ctl_reg;
	ctl_s ctl_next;

	logic [NUM_REGS*STATE_W-1:0] rf_rdata;
	logic [STATE_W-1:0]          src_val;
	logic [STATE_W-1:0]          dst_val;
	logic [STATE_W-1:0]          rot_val;
	logic [ADDR_W-1:0]           eff_addr;
	logic                        we;
	logic [SEL_W-1:0]            waddr;
	logic [STATE_W-1:0]          wdata;

	// Storage: two 128-bit entries, apart from the general registers
	state_rf_mem #(
		.DEPTH (NUM_REGS),
		.WIDTH (STATE_W)
	) u_mem (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.we_i      (we),
		.waddr_i   (waddr),
		.wdata_i   (wdata),
		.rdata_o   (rf_rdata)
	); // RL1

	assign src_val  = rf_rdata[cmd_i.src*STATE_W +: STATE_W];
	assign dst_val  = rf_rdata[cmd_i.dst*STATE_W +: STATE_W];
	assign eff_addr = cmd_i.base + cmd_i.imm; // RL3

	// Row rotation: byte k sits at bits 127-8k downto 120-8k
	function automatic logic [BYTE_W-1:0] get_byte(
		input logic [STATE_W-1:0] v,
		input int unsigned        k
	);
		get_byte = v[STATE_W-1-k*BYTE_W -: BYTE_W]; // RL7
	endfunction : get_byte

	// Output byte i = r + 4c takes input byte r + 4((c + r) mod 4)
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BYTES; gi++) begin : g_rot
			localparam int unsigned R = gi % 4;
			localparam int unsigned C = gi / 4;
			localparam int unsigned S = R + 4 * ((C + R) % 4);
			// RL8 RL9 RL10 RL11 RL12 RL16
			assign rot_val[STATE_W-1-gi*BYTE_W -: BYTE_W] =
				get_byte(dst_val, S); // RL14
		end
	endgenerate

	// Register file write select
	always_comb begin
		we    = 1'b0;
		waddr = cmd_i.dst;
		wdata = rot_val;
		if (ctl_reg.st == ST_WAIT) begin
			// Stores only report completion; entries stay put
			we    = mem_rsp_i.valid && !ctl_reg.req.write;
			waddr = ctl_reg.ld_dst;
			wdata = mem_rsp_i.rdata; // RL4 RL15
		end else if (cmd_i.valid) begin
			case (cmd_i.op)
				OP_MOVE: begin
					we    = 1'b1;
					wdata = src_val; // RL2
				end
				OP_SHIFT: begin
					we    = 1'b1; // RL13 RL6
				end
				OP_WRITE: begin
					we    = 1'b1;
					wdata = cmd_i.wdata; // RL6
				end
				default: begin
					we = 1'b0;
				end
			endcase
		end
	end

	// Controller
	always_comb begin
		ctl_next           = ctl_reg;
		ctl_next.req.valid = 1'b0;
		ctl_next.done      = 1'b0;
		case (ctl_reg.st)
			ST_IDLE: begin
				if (cmd_i.valid) begin
					case (cmd_i.op)
						OP_LOAD, OP_STORE: begin
							if ((eff_addr & ALIGN_MASK) != '0) begin
								ctl_next.align_err = 1'b1; // RL5
								ctl_next.done      = 1'b1;
							end else begin
								ctl_next.align_err = 1'b0;
								ctl_next.req.valid = 1'b1;
								ctl_next.req.write = (cmd_i.op == OP_STORE);
								ctl_next.req.addr  = eff_addr;
								ctl_next.req.wdata = src_val; // RL4 RL15
								ctl_next.ld_dst    = cmd_i.dst;
								ctl_next.busy      = 1'b1;
								ctl_next.st        = ST_WAIT;
							end
						end
						OP_MOVE, OP_SHIFT, OP_WRITE: begin
							ctl_next.align_err = 1'b0;
							ctl_next.done      = 1'b1;
						end
						default: begin
							ctl_next.done = 1'b0;
						end
					endcase
				end
			end
			ST_WAIT: begin
				if (mem_rsp_i.valid) begin
					ctl_next.busy = 1'b0;
					ctl_next.done = 1'b1;
					ctl_next.st   = ST_IDLE;
				end
			end
			default: begin
				ctl_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctl_reg <= '{st: ST_IDLE, req: '0, default: '0};
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	assign busy_o      = ctl_reg.busy;
	assign mem_req_o   = ctl_reg.req;
	assign align_err_o = ctl_reg.align_err;
	assign done_o      = ctl_reg.done;
	assign state_o     = rf_rdata;

	// Assertions
	a_rot_row_one: assert property (@(posedge mclk_i) // RL8
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_SHIFT && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W+STATE_W-1 -: 8]
			== $past(dst_val[127:120])))
		else $error("row rotation changed byte 0");
	a_rot_byte_one: assert property (@(posedge mclk_i) // RL10
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_SHIFT && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W+119 -: 8]
			== $past(dst_val[87:80])))
		else $error("row two byte 1 not from byte 5");
	a_rot_byte_two: assert property (@(posedge mclk_i) // RL11
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_SHIFT && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W+111 -: 8]
			== $past(dst_val[47:40])))
		else $error("row three byte 2 not from byte 10");
	a_rot_byte_three: assert property (@(posedge mclk_i) // RL12
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_SHIFT && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W+103 -: 8]
			== $past(dst_val[7:0])))
		else $error("row four byte 3 not from byte 15");
	a_rot_byte_last: assert property (@(posedge mclk_i) // RL16
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_SHIFT && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W+7 -: 8]
			== $past(dst_val[39:32])))
		else $error("byte 15 not from byte 11");
	a_move_copy: assert property (@(posedge mclk_i) // RL2
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_MOVE && ctl_reg.st == ST_IDLE)
		|=> (state_o[$past(cmd_i.dst)*STATE_W +: STATE_W]
			== $past(src_val)))
		else $error("move did not copy source");
	a_req_aligned: assert property (@(posedge mclk_i) // RL5
		disable iff (sys_rst_i)
		mem_req_o.valid |-> (mem_req_o.addr[ALIGN_BITS-1:0] == 4'h0))
		else $error("unaligned memory request issued");
	a_req_addr: assert property (@(posedge mclk_i) // RL3
		disable iff (sys_rst_i)
		(cmd_i.valid && cmd_i.op == OP_LOAD && ctl_reg.st == ST_IDLE
			&& eff_addr[3:0] == 4'h0)
		|=> (mem_req_o.valid && !mem_req_o.write
			&& mem_req_o.addr == $past(cmd_i.base + cmd_i.imm)))
		else $error("load address not base plus immediate");
	a_load_write: assert property (@(posedge mclk_i) // RL4
		disable iff (sys_rst_i)
		(ctl_reg.st == ST_WAIT && mem_rsp_i.valid && !ctl_reg.req.write)
		|=> (state_o[$past(ctl_reg.ld_dst)*STATE_W +: STATE_W]
			== $past(mem_rsp_i.rdata)) && done_o && !busy_o)
		else $error("load data not written in one access");
	a_store_keep: assert property (@(posedge mclk_i) // RL4
		disable iff (sys_rst_i)
		(ctl_reg.st == ST_WAIT && mem_rsp_i.valid && ctl_reg.req.write)
		|=> ($stable(state_o) && done_o && !busy_o))
		else $error("store changed a state entry");
	a_busy_hold: assert property (@(posedge mclk_i) // RL4
		disable iff (sys_rst_i)
		(ctl_reg.st == ST_WAIT && !mem_rsp_i.valid)
		|=> ($stable(state_o) && busy_o))
		else $error("entry changed while waiting on memory");
endmodule : aes_state_regfile_shiftrow

// file: hw/state_rf_mem.sv
// Two-entry 128-bit storage with registered read ports
module state_rf_mem
	import state_rf_pkg::*;
#(
	parameter int unsigned DEPTH = NUM_REGS,
	parameter int unsigned WIDTH = STATE_W
) (
	// Clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     sys_rst_i,
	// Write port
	input  wire logic                     we_i,
	input  wire logic [SEL_W-1:0]         waddr_i,
	input  wire logic [WIDTH-1:0]         wdata_i,
	// Read ports (all entries, registered)
	output logic      [DEPTH*WIDTH-1:0]   rdata_o
);
	logic [DEPTH*WIDTH-1:0] mem_reg;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			mem_reg <= '0;
		end else if (we_i) begin
			mem_reg[waddr_i*WIDTH +: WIDTH] <= wdata_i;
		end
	end

	assign rdata_o = mem_reg;
endmodule : state_rf_mem

// file: shared/state_rf_pkg.sv
// Package: widths, opcodes and layout for the 128-bit state register file
package state_rf_pkg;
	localparam int unsigned STATE_W    = 128;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned NUM_BYTES  = 16;
	localparam int unsigned NUM_REGS   = 2;
	localparam int unsigned SEL_W      = 1;
	localparam int unsigned ADDR_W     = 32;
	localparam int unsigned ALIGN_BITS = 4;
	localparam logic [ADDR_W-1:0] ALIGN_MASK = 32'h0000000F;
	localparam logic [STATE_W-1:0] STATE_RST = 128'h0;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_MOVE  = 3'h1,
		OP_LOAD  = 3'h2,
		OP_STORE = 3'h3,
		OP_SHIFT = 3'h4,
		OP_WRITE = 3'h5
	} state_op_e;

	// Instruction from the host decode stage
	typedef struct packed {
		logic              valid;
		state_op_e         op;
		logic [SEL_W-1:0]  dst;
		logic [SEL_W-1:0]  src;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] imm;
		logic [STATE_W-1:0] wdata;
	} state_cmd_s;

	// Request to the 128-bit load/store unit
	typedef struct packed {
		logic               valid;
		logic               write;
		logic [ADDR_W-1:0]  addr;
		logic [STATE_W-1:0] wdata;
	} mem_req_s;

	// Answer from the load/store unit
	typedef struct packed {
		logic               valid;
		logic [STATE_W-1:0] rdata;
	} mem_rsp_s;
endpackage : state_rf_pkg
